// ---- src/fp_break_map.svh ----
`ifndef FP_BREAK_MAP_SVH
`define FP_BREAK_MAP_SVH

// Pin levels of active-low signals.
`define PIN_ASSERTED 1'b0
`define PIN_DEASSERTED 1'b1

// Reset values of the shared output and the selected operating point.
`define FP_BREAK_RESET 1'b1
`define PERF_POINT_RESET 1'b0
`define POINT_RESET 16'h0000

`endif

// ---- src/fp_break_pkg.sv ----
package fp_break_pkg;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_DEEP_SLEEP = 2'b10
    } power_state_t;

    typedef struct packed {
        logic fp_error;
        logic fp_error_masked;
        logic break_event;
    } core_events_t;

    typedef struct packed {
        logic [7:0] bus_ratio;
        logic [7:0] core_voltage;
    } operating_point_t;

endpackage : fp_break_pkg

// ---- src/perf_select.sv ----
`timescale 1ns/1ps
`include "fp_break_map.svh"

module perf_select #(
    parameter logic [7:0] HIGH_RATIO = 8'h10,
    parameter logic [7:0] HIGH_VOLTAGE = 8'h30,
    parameter logic [7:0] LOW_RATIO = 8'h08,
    parameter logic [7:0] LOW_VOLTAGE = 8'h20
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Power state and select pin.
    input wire fp_break_pkg::power_state_t state_in,
    input wire logic perf_state_select_n_in,
    // Selected operating point.
    output fp_break_pkg::operating_point_t point_out,
    output logic high_perf_out
);

    fp_break_pkg::power_state_t state_prev_reg;
    fp_break_pkg::power_state_t state_prev_next;
    logic high_perf_reg;
    logic high_perf_next;
    fp_break_pkg::operating_point_t point_reg;
    fp_break_pkg::operating_point_t point_next;

    function automatic fp_break_pkg::operating_point_t point_of(input logic high);
        fp_break_pkg::operating_point_t p;
        p.bus_ratio = high ? HIGH_RATIO : LOW_RATIO;
        p.core_voltage = high ? HIGH_VOLTAGE : LOW_VOLTAGE;
        return p;
    endfunction : point_of

    always_comb begin
        state_prev_next = state_in;
        high_perf_next = high_perf_reg;
        // Latched on entry to sleep, followed while in deep sleep, else held.
        if (state_in == fp_break_pkg::PWR_SLEEP &&
            state_prev_reg != fp_break_pkg::PWR_SLEEP) begin
            high_perf_next = (perf_state_select_n_in == `PIN_ASSERTED);
        end else if (state_in == fp_break_pkg::PWR_DEEP_SLEEP) begin
            high_perf_next = (perf_state_select_n_in == `PIN_ASSERTED);
        end
        point_next = point_of(high_perf_next);
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_prev_reg <= fp_break_pkg::PWR_NORMAL;
            high_perf_reg <= `PERF_POINT_RESET;
            point_reg <= `POINT_RESET;
        end else begin
            state_prev_reg <= state_prev_next;
            high_perf_reg <= high_perf_next;
            point_reg <= point_next;
        end
    end

    assign point_out = point_reg;
    assign high_perf_out = high_perf_reg;

    property p_select_ignored;
        @(posedge clk_in) disable iff (reset_in)
        (state_in == fp_break_pkg::PWR_NORMAL) |=> $stable(high_perf_reg);
    endproperty
    a_select_ignored: assert property (p_select_ignored) else $error("select leaked");

    property p_deep_follow;
        @(posedge clk_in) disable iff (reset_in)
        (state_in == fp_break_pkg::PWR_DEEP_SLEEP) |=>
            (high_perf_reg == ($past(perf_state_select_n_in) == `PIN_ASSERTED));
    endproperty
    a_deep_follow: assert property (p_deep_follow) else $error("select not followed");

endmodule : perf_select

// ---- src/fp_error_break.sv ----
`timescale 1ns/1ps
`include "fp_break_map.svh"

module fp_error_break (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Platform pins.
    input wire logic stop_clock_request_n_in,
    input wire logic perf_state_select_n_in,
    // Core side.
    input wire fp_break_pkg::core_events_t events_in,
    input wire fp_break_pkg::power_state_t state_in,
    // Platform outputs.
    output logic fp_error_break_n_out,
    // Core outputs.
    output fp_break_pkg::operating_point_t point_out,
    output logic high_perf_out
);

    logic stop_active;
    logic break_hold_reg;
    logic break_hold_next;
    logic out_n_reg;
    logic out_n_next;

    // An error reaches the pin only when the core has not masked it.
    function automatic logic error_shown(input fp_break_pkg::core_events_t ev);
        return ev.fp_error && !ev.fp_error_masked;
    endfunction : error_shown

    assign stop_active = (stop_clock_request_n_in == `PIN_ASSERTED);

    // ------------------------------------------------------------
    // Shared error and break output
    // ------------------------------------------------------------
    always_comb begin
        break_hold_next = break_hold_reg;
        // Release of stop-clock clears the hold at once, so a new stop period starts clean.
        if (!stop_active) begin
            break_hold_next = 1'b0;
        end else if (events_in.break_event) begin
            break_hold_next = 1'b1;
        end
        if (stop_active) begin
            out_n_next = break_hold_next ? `PIN_ASSERTED : `PIN_DEASSERTED;
        end else begin
            out_n_next = error_shown(events_in) ?
                `PIN_ASSERTED : `PIN_DEASSERTED;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            break_hold_reg <= 1'b0;
            out_n_reg <= `FP_BREAK_RESET;
        end else begin
            break_hold_reg <= break_hold_next;
            out_n_reg <= out_n_next;
        end
    end

    assign fp_error_break_n_out = out_n_reg;

    // ------------------------------------------------------------
    // Operating point selection
    // ------------------------------------------------------------
    perf_select u_perf_select (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .state_in(state_in),
        .perf_state_select_n_in(perf_state_select_n_in),
        .point_out(point_out),
        .high_perf_out(high_perf_out)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_break_seen;
        stop_active && events_in.break_event;
    endsequence

    sequence s_held_low;
        (fp_error_break_n_out == `PIN_ASSERTED) [*2];
    endsequence

    property p_fp_error;
        @(posedge clk_in) disable iff (reset_in)
        (!stop_active && events_in.fp_error && !events_in.fp_error_masked) |=>
            (fp_error_break_n_out == `PIN_ASSERTED);
    endproperty
    a_fp_error: assert property (p_fp_error) else $error("unmasked fp error not shown");

    property p_masked_quiet;
        @(posedge clk_in) disable iff (reset_in)
        (!stop_active && (!events_in.fp_error || events_in.fp_error_masked)) |=>
            (fp_error_break_n_out == `PIN_DEASSERTED);
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("pin low, no error");

    property p_break_shown;
        @(posedge clk_in) disable iff (reset_in)
        s_break_seen |=> (fp_error_break_n_out == `PIN_ASSERTED);
    endproperty
    a_break_shown: assert property (p_break_shown) else $error("break event not shown");

    property p_break_held;
        @(posedge clk_in) disable iff (reset_in)
        s_break_seen ##1 stop_active |=> s_held_low or !stop_active;
    endproperty
    a_break_held: assert property (p_break_held) else $error("break dropped early");

    property p_release_clears;
        @(posedge clk_in) disable iff (reset_in)
        $rose(stop_clock_request_n_in) |-> !break_hold_next;
    endproperty
    a_release_clears: assert property (p_release_clears) else $error("break kept");

    property p_no_break_idle;
        @(posedge clk_in) disable iff (reset_in)
        (stop_active && !break_hold_next) |=> (fp_error_break_n_out == `PIN_DEASSERTED);
    endproperty
    a_no_break_idle: assert property (p_no_break_idle) else $error("stray break");

    property p_fp_hidden;
        @(posedge clk_in) disable iff (reset_in)
        (stop_active && !events_in.break_event && !break_hold_reg) |=>
            (fp_error_break_n_out == `PIN_DEASSERTED);
    endproperty
    a_fp_hidden: assert property (p_fp_hidden) else $error("fp error leaked");

    property p_run_no_break;
        @(posedge clk_in) disable iff (reset_in)
        (!stop_active && events_in.break_event && !error_shown(events_in)) |=>
            (fp_error_break_n_out == `PIN_DEASSERTED);
    endproperty
    a_run_no_break: assert property (p_run_no_break) else $error("break leaked");

    // ------------------------------------------------------------
    // Checks: break hold and release
    // ------------------------------------------------------------
    // A fresh stop-clock period must not inherit a break from the last one.
    sequence s_stop_entry;
        $fell(stop_clock_request_n_in) && !events_in.break_event;
    endsequence

    sequence s_hold_then_release;
        (stop_active && break_hold_reg) ##1 (!stop_active && !error_shown(events_in));
    endsequence

    property p_fresh_stop_quiet;
        @(posedge clk_in) disable iff (reset_in)
        s_stop_entry |=> (fp_error_break_n_out == `PIN_DEASSERTED);
    endproperty
    a_fresh_stop_quiet: assert property (p_fresh_stop_quiet) else $error("stale break");

    property p_hold_kept;
        @(posedge clk_in) disable iff (reset_in)
        (stop_active && break_hold_reg) |=> (fp_error_break_n_out == `PIN_ASSERTED);
    endproperty
    a_hold_kept: assert property (p_hold_kept) else $error("held break lost");

    property p_release_frees;
        @(posedge clk_in) disable iff (reset_in)
        s_hold_then_release |=> (fp_error_break_n_out == `PIN_DEASSERTED);
    endproperty
    a_release_frees: assert property (p_release_frees) else $error("pin not freed");

    // ------------------------------------------------------------
    // Checks: operating point
    // ------------------------------------------------------------
    sequence s_sleep_entry;
        (state_in != fp_break_pkg::PWR_SLEEP) ##1 (state_in == fp_break_pkg::PWR_SLEEP);
    endsequence

    sequence s_sleep_stay;
        (state_in == fp_break_pkg::PWR_SLEEP) [*2];
    endsequence

    sequence s_normal_stay;
        (state_in == fp_break_pkg::PWR_NORMAL) [*2];
    endsequence

    sequence s_deep_select_move;
        (state_in == fp_break_pkg::PWR_DEEP_SLEEP) ##1
        (state_in == fp_break_pkg::PWR_DEEP_SLEEP && $changed(perf_state_select_n_in));
    endsequence

    property p_sleep_latch;
        @(posedge clk_in) disable iff (reset_in)
        s_sleep_entry |=> (high_perf_out == ($past(perf_state_select_n_in) == `PIN_ASSERTED));
    endproperty
    a_sleep_latch: assert property (p_sleep_latch) else $error("entry not latched");

    property p_sleep_hold;
        @(posedge clk_in) disable iff (reset_in)
        s_sleep_stay |=> $stable(high_perf_out);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("select moved in sleep");

    property p_normal_point;
        @(posedge clk_in) disable iff (reset_in)
        s_normal_stay |=> $stable(point_out);
    endproperty
    a_normal_point: assert property (p_normal_point) else $error("point moved");

    property p_deep_move;
        @(posedge clk_in) disable iff (reset_in)
        s_deep_select_move |=> $changed(high_perf_out);
    endproperty
    a_deep_move: assert property (p_deep_move) else $error("deep select lost");

    property p_point_tracks;
        @(posedge clk_in) disable iff (reset_in)
        $changed(high_perf_out) |-> $changed(point_out);
    endproperty
    a_point_tracks: assert property (p_point_tracks) else $error("point not switched");

endmodule : fp_error_break

// ---- bench/platform_model.sv ----
`timescale 1ns/1ps
module platform_model (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_in,
    // Bench controls.
    input wire logic stop_req_in,
    input wire logic slow_in,
    // Device pins.
    input wire logic break_n_in,
    output logic stop_clock_request_n_out
);
    logic [2:0] wait_reg;
    logic done_reg;
    always @(negedge clk_in or posedge reset_in) begin
        if (reset_in || !stop_req_in) begin
            stop_clock_request_n_out <= 1'b1;
            wait_reg <= 3'h0;
            done_reg <= 1'b0;
        end else if (!done_reg && !break_n_in && !stop_clock_request_n_out) begin
            // A pending break is answered by releasing the request, promptly or late.
            wait_reg <= wait_reg + 3'h1;
            if (wait_reg >= (slow_in ? 3'h4 : 3'h0)) begin
                stop_clock_request_n_out <= 1'b1;
                done_reg <= 1'b1;
            end
        end else if (!done_reg) begin
            stop_clock_request_n_out <= 1'b0;
        end
    end
endmodule : platform_model

// ---- bench/fp_error_break_tb.sv ----
`timescale 1ns/1ps
module fp_error_break_tb;
    logic clk_in = 1'b0, reset_in = 1'b0, sel_n = 1'b1, stop_req = 1'b0, slow = 1'b0;
    logic stop_n, out_n, high, save;
    fp_break_pkg::core_events_t ev = 3'h0;
    fp_break_pkg::power_state_t st = fp_break_pkg::PWR_NORMAL;
    fp_break_pkg::operating_point_t pt;
    logic [31:0] rng = 32'h6fa0, r;
    int n_mismatch = 0, checks = 0, cycles = 0;
    fp_error_break DUT (.clk_in(clk_in), .reset_in(reset_in),
        .stop_clock_request_n_in(stop_n), .perf_state_select_n_in(sel_n),
        .events_in(ev), .state_in(st), .fp_error_break_n_out(out_n),
        .point_out(pt), .high_perf_out(high));
    platform_model partner (.clk_in(clk_in), .reset_in(reset_in), .stop_req_in(stop_req),
        .slow_in(slow), .break_n_in(out_n), .stop_clock_request_n_out(stop_n));
    always #12.5 clk_in = ~clk_in;
    function automatic logic [31:0] rand32();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rand32
    function automatic logic exp_fp(fp_break_pkg::core_events_t e);
        return !(e.fp_error && !e.fp_error_masked);
    endfunction : exp_fp
    function automatic fp_break_pkg::operating_point_t exp_pt(logic hi);
        return hi ? {8'h10, 8'h30} : {8'h08, 8'h20};
    endfunction : exp_pt
    task automatic chk_pin(logic got, logic exp, string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s", $time, what);
        end
    endtask : chk_pin
    task automatic chk_point(fp_break_pkg::operating_point_t got, logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t point", $time);
        end
    endtask : chk_point
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        reset_in = 1'b1;
        repeat (10) @(negedge clk_in);
        chk_pin(out_n, 1'b1, "reset out");
        chk_pin(high, 1'b0, "reset high");
        chk_point(pt, 16'h0);
        reset_in = 1'b0;
        repeat (40) begin
            r = rand32();
            ev = r[2:0];
            @(negedge clk_in);
            chk_pin(out_n, exp_fp(ev), "fp error");
        end
        $display("test fp error done");
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            stop_req <= 1'b1;
            ev = 3'h4;
            repeat (3) @(negedge clk_in);
            chk_pin(out_n, 1'b1, "fp hidden");
            ev = 3'h1;
            @(negedge clk_in);
            chk_pin(out_n, 1'b0, "break");
            ev = 3'h0;
            for (int i = 0; i < 3 && slow; i++) begin
                @(negedge clk_in);
                chk_pin(out_n, 1'b0, "break held");
            end
            for (int i = 0; i < 10 && stop_n !== 1'b1; i++) @(negedge clk_in);
            @(negedge clk_in);
            chk_pin(out_n, 1'b1, "break cleared");
            stop_req <= 1'b0;
            @(negedge clk_in);
            $display("test break done");
        end
        for (int k = 0; k < 6; k++) begin
            r = rand32();
            save = high;
            st = fp_break_pkg::PWR_NORMAL;
            sel_n = r[1];
            repeat (2) @(negedge clk_in);
            chk_pin(high, save, "normal ignored");
            chk_point(pt, exp_pt(save));
            st = fp_break_pkg::PWR_SLEEP;
            sel_n = r[2];
            @(negedge clk_in);
            sel_n = ~r[2];
            repeat (2) @(negedge clk_in);
            chk_pin(high, ~r[2], "sleep latch");
            chk_point(pt, exp_pt(~r[2]));
            st = fp_break_pkg::PWR_DEEP_SLEEP;
            repeat (4) begin
                r = rand32();
                sel_n = r[0];
                @(negedge clk_in);
                chk_pin(high, ~r[0], "deep follow");
                chk_point(pt, exp_pt(~r[0]));
            end
            $display("test select done");
        end
        complete_run();
    end
endmodule : fp_error_break_tb
